/* core/arst_map.vh */
// Register map, field positions, reset values and timing constants of the
// auto-recloser status stage. Included by core/arst_status.v only.
`ifndef ARST_MAP_VH
`define ARST_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ARST_CTRL_OFS 8'h00
`define ARST_ARC_OFS 8'h04
`define ARST_DEAD_OFS 8'h08
`define ARST_RECLAIM_OFS 8'h0c
`define ARST_LOCKOUT_OFS 8'h10
`define ARST_STATUS_OFS 8'h14
`define ARST_SHOT_OFS 8'h18

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ARST_CTRL_MODE_BIT 0
`define ARST_CTRL_SEL_BIT 1
`define ARST_CTRL_SHOTS_LSB 4
`define ARST_CTRL_SHOTS_MSB 6
`define ARST_SEL_YES 1'b0
`define ARST_SEL_NO 1'b1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ARST_MODE_RST 1'b0
`define ARST_SEL_RST 1'b1
`define ARST_SHOTS_RST 3'h1
`define ARST_ARC_RST 16'h0064
`define ARST_DEAD_RST 16'h01f4
`define ARST_RECLAIM_RST 16'h2710
`define ARST_LOCKOUT_RST 16'h2710

// ----------------------------------------------------------------------
// Timing: timers count in 1 ms ticks of the 100 MHz clock
// ----------------------------------------------------------------------
`define ARST_TICK_NS 1000000
`define ARST_CLK_NS 10
`define ARST_TICK_CYCLES (`ARST_TICK_NS / `ARST_CLK_NS)

`endif

/* core/arst_status.v */
// Auto-recloser sequencer and its status indications, with a classic
// Wishbone slave for settings and status.
// Assumes the breaker status inputs come from the separate object control
// function, which alone issues breaker open and close commands.
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "arst_map.vh"

module arst_status #(
    parameter TICK_CYCLES = `ARST_TICK_CYCLES,
    parameter MAX_SHOTS = 5
) (
    // Clock, reset, enable
    input wire clk,
    input wire rst,
    input wire ce,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Control inputs
    input wire external_enable_input,
    input wire manual_reset,
    input wire locking,
    input wire critical_request,
    input wire reclose_request_1,
    input wire reclose_request_2,
    input wire reclose_request_3,
    input wire reclose_request_4,
    input wire reclose_request_5,
    // Breaker status from object control
    input wire breaker_open,
    input wire breaker_closed,
    // Indications
    output reg recloser_enabled_ind,
    output reg recloser_disabled_ind,
    output reg reclose_in_progress_ind,
    output reg recloser_running_ind,
    output reg [4:0] request_active_ind,
    output reg [4:0] shot_running_ind,
    output reg sequence_done_ind,
    output reg final_trip_ind,
    output reg dead_time_ind,
    output reg arcing_time_ind,
    output reg reclaim_time_ind,
    output reg recloser_ready_ind,
    output reg lockout_success_ind,
    output reg inhibit_ind,
    output reg locked_ind
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam [2:0] ST_INHIBIT = 3'h0;
    localparam [2:0] ST_READY = 3'h1;
    localparam [2:0] ST_ARC = 3'h2;
    localparam [2:0] ST_WAIT_OPEN = 3'h3;
    localparam [2:0] ST_DEAD = 3'h4;
    localparam [2:0] ST_WAIT_CLOSE = 3'h5;
    localparam [2:0] ST_RECLAIM = 3'h6;
    localparam [2:0] ST_LOCKED = 3'h7;

    // Priority encoder: index 1..5 of the lowest-numbered active request.
    function [2:0] req_pick;
        input [4:0] r;
        begin
            if (r[0])
                req_pick = 3'h1;
            else if (r[1])
                req_pick = 3'h2;
            else if (r[2])
                req_pick = 3'h3;
            else if (r[3])
                req_pick = 3'h4;
            else if (r[4])
                req_pick = 3'h5;
            else
                req_pick = 3'h0;
        end
    endfunction

    // One-hot of an index 1..5; zero gives no bit, so only one is ever set.
    function [4:0] one_hot;
        input [2:0] idx;
        begin
            one_hot = 5'h00;
            if (idx != 3'h0 && idx <= 3'h5)
                one_hot[idx - 3'h1] = 1'b1;
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    reg mode_reg;
    reg sel_reg;
    reg [2:0] shots_reg;
    reg [15:0] arc_reg;
    reg [15:0] dead_reg;
    reg [15:0] reclaim_reg;
    reg [15:0] lockout_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [2:0] shot_reg;
    reg [2:0] shot_next;
    reg [2:0] req_reg;
    reg [2:0] req_next;
    reg [15:0] timer_reg;
    reg [15:0] timer_next;
    reg [16:0] lockout_cnt_reg;
    reg [16:0] lockout_cnt_next;
    reg [31:0] tick_cnt_reg;
    reg tick_reg;
    reg final_reg;
    reg final_next;
    reg lo_succ_reg;
    reg lo_succ_next;

    wire [4:0] req_vec;
    wire [2:0] req_now;
    wire enabled;
    wire bus_req;
    wire bus_wr;
    wire timer_done;
    wire [2:0] shots_lim;

    assign req_vec = {reclose_request_5, reclose_request_4,
                      reclose_request_3, reclose_request_2,
                      reclose_request_1};
    assign req_now = req_pick(req_vec);
    // With the on/off input not in use the function is on whenever mode_reg is set.
    assign enabled = mode_reg &&
                     (sel_reg == `ARST_SEL_NO || external_enable_input);
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    assign timer_done = (timer_reg == 16'h0000);
    // A shot count of zero or above the maximum is clamped.
    assign shots_lim = (shots_reg == 3'h0) ? 3'h1 :
                       (shots_reg > MAX_SHOTS[2:0]) ? MAX_SHOTS[2:0] :
                       shots_reg;

    // ------------------------------------------------------------------
    // Wishbone slave: ack one cycle after the strobe, dropped the next.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            mode_reg <= `ARST_MODE_RST;
            sel_reg <= `ARST_SEL_RST;
            shots_reg <= `ARST_SHOTS_RST;
            arc_reg <= `ARST_ARC_RST;
            dead_reg <= `ARST_DEAD_RST;
            reclaim_reg <= `ARST_RECLAIM_RST;
            lockout_reg <= `ARST_LOCKOUT_RST;
        end else if (ce) begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h00000000;
            if (bus_wr) begin
                case (wb_adr_i)
                    `ARST_CTRL_OFS: begin
                        mode_reg <= wb_dat_i[`ARST_CTRL_MODE_BIT];
                        sel_reg <= wb_dat_i[`ARST_CTRL_SEL_BIT];
                        shots_reg <= wb_dat_i[`ARST_CTRL_SHOTS_MSB:
                                              `ARST_CTRL_SHOTS_LSB];
                    end
                    `ARST_ARC_OFS: arc_reg <= wb_dat_i[15:0];
                    `ARST_DEAD_OFS: dead_reg <= wb_dat_i[15:0];
                    `ARST_RECLAIM_OFS: reclaim_reg <= wb_dat_i[15:0];
                    `ARST_LOCKOUT_OFS: lockout_reg <= wb_dat_i[15:0];
                    default: ;
                endcase
            end
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `ARST_CTRL_OFS:
                        wb_dat_o <= {25'h0000000, shots_reg, 2'h0,
                                     sel_reg, mode_reg};
                    `ARST_ARC_OFS: wb_dat_o <= {16'h0000, arc_reg};
                    `ARST_DEAD_OFS: wb_dat_o <= {16'h0000, dead_reg};
                    `ARST_RECLAIM_OFS: wb_dat_o <= {16'h0000, reclaim_reg};
                    `ARST_LOCKOUT_OFS: wb_dat_o <= {16'h0000, lockout_reg};
                    `ARST_STATUS_OFS:
                        wb_dat_o <= {24'h000000, lo_succ_reg, final_reg,
                                     enabled, 2'h0, state_reg};
                    `ARST_SHOT_OFS:
                        wb_dat_o <= {16'h0000, timer_reg[15:0]} &
                                    32'h0000ffff |
                                    {21'h000000, req_reg, 5'h00, shot_reg}
                                    << 16;
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            tick_cnt_reg <= 32'h00000000;
            tick_reg <= 1'b0;
        end else if (ce) begin
            if (tick_cnt_reg >= TICK_CYCLES - 1) begin
                tick_cnt_reg <= 32'h00000000;
                tick_reg <= 1'b1;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
                tick_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        shot_next = shot_reg;
        req_next = req_reg;
        final_next = final_reg;
        lo_succ_next = lo_succ_reg;
        timer_next = timer_reg;
        if (tick_reg && !timer_done)
            timer_next = timer_reg - 16'h0001;
        lockout_cnt_next = lockout_cnt_reg;
        if (tick_reg && lockout_cnt_reg != 17'h00000)
            lockout_cnt_next = lockout_cnt_reg - 17'h00001;
        case (state_reg)
            ST_INHIBIT: begin
                if (enabled)
                    state_next = ST_READY;
            end
            ST_READY: begin
                if (!enabled) begin
                    state_next = ST_INHIBIT;
                end else if (req_now != 3'h0) begin
                    // A fault inside the lockout delay locks out instead of starting a shot.
                    if (lockout_cnt_reg != 17'h00000) begin
                        state_next = ST_LOCKED;
                        lo_succ_next = 1'b1;
                    end else begin
                        state_next = ST_ARC;
                        shot_next = 3'h1;
                        req_next = req_now;
                        timer_next = arc_reg;
                    end
                end
            end
            ST_ARC: begin
                if (req_now == 3'h0) begin
                    state_next = ST_RECLAIM;
                    timer_next = reclaim_reg;
                end else if (timer_done) begin
                    state_next = ST_WAIT_OPEN;
                end else if (req_now < req_reg) begin
                    req_next = req_now;
                end
            end
            ST_WAIT_OPEN: begin
                if (breaker_open) begin
                    state_next = ST_DEAD;
                    timer_next = dead_reg;
                end
            end
            ST_DEAD: begin
                if (timer_done)
                    state_next = ST_WAIT_CLOSE;
            end
            ST_WAIT_CLOSE: begin
                if (breaker_closed) begin
                    state_next = ST_RECLAIM;
                    timer_next = reclaim_reg;
                end
            end
            ST_RECLAIM: begin
                if (req_now != 3'h0) begin
                    if (shot_reg >= shots_lim) begin
                        state_next = ST_LOCKED;
                        final_next = 1'b1;
                    end else begin
                        state_next = ST_ARC;
                        shot_next = shot_reg + 3'h1;
                        req_next = req_now;
                        timer_next = arc_reg;
                    end
                end else if (timer_done) begin
                    state_next = enabled ? ST_READY : ST_INHIBIT;
                    shot_next = 3'h0;
                    req_next = 3'h0;
                    lockout_cnt_next = {1'b0, lockout_reg};
                end
            end
            ST_LOCKED: begin
                if (manual_reset) begin
                    state_next = enabled ? ST_READY : ST_INHIBIT;
                    final_next = 1'b0;
                    lo_succ_next = 1'b0;
                end
            end
            default: state_next = ST_INHIBIT;
        endcase
        if (state_reg != ST_LOCKED && (critical_request || locking)) begin
            state_next = ST_LOCKED;
            shot_next = 3'h0;
            req_next = 3'h0;
        end
        if (state_next == ST_LOCKED || state_next == ST_INHIBIT) begin
            shot_next = 3'h0;
            req_next = 3'h0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_INHIBIT;
            shot_reg <= 3'h0;
            req_reg <= 3'h0;
            timer_reg <= 16'h0000;
            lockout_cnt_reg <= 17'h00000;
            final_reg <= 1'b0;
            lo_succ_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            shot_reg <= shot_next;
            req_reg <= req_next;
            timer_reg <= timer_next;
            lockout_cnt_reg <= lockout_cnt_next;
            final_reg <= final_next;
            lo_succ_reg <= lo_succ_next;
        end
    end

    // ------------------------------------------------------------------
    // Indications, registered one cycle behind the sequencer.
    // No breaker command leaves this block; object control owns them.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            recloser_enabled_ind <= 1'b0;
            recloser_disabled_ind <= 1'b0;
            reclose_in_progress_ind <= 1'b0;
            recloser_running_ind <= 1'b0;
            request_active_ind <= 5'h00;
            shot_running_ind <= 5'h00;
            sequence_done_ind <= 1'b0;
            final_trip_ind <= 1'b0;
            dead_time_ind <= 1'b0;
            arcing_time_ind <= 1'b0;
            reclaim_time_ind <= 1'b0;
            recloser_ready_ind <= 1'b0;
            lockout_success_ind <= 1'b0;
            inhibit_ind <= 1'b0;
            locked_ind <= 1'b0;
        end else if (ce) begin
            recloser_enabled_ind <= enabled;
            recloser_disabled_ind <= mode_reg &&
                sel_reg == `ARST_SEL_YES && !external_enable_input;
            reclose_in_progress_ind <= state_reg == ST_DEAD;
            dead_time_ind <= state_reg == ST_DEAD;
            recloser_running_ind <= state_reg >= ST_ARC &&
                                    state_reg <= ST_RECLAIM;
            request_active_ind <= one_hot(req_reg);
            shot_running_ind <= one_hot(shot_reg);
            sequence_done_ind <= state_reg == ST_RECLAIM &&
                                 shot_reg >= shots_lim &&
                                 !timer_done;
            final_trip_ind <= final_reg;
            arcing_time_ind <= state_reg == ST_ARC && !timer_done;
            reclaim_time_ind <= state_reg == ST_RECLAIM &&
                                !timer_done;
            recloser_ready_ind <= state_reg == ST_READY &&
                                  lockout_cnt_reg == 17'h00000;
            lockout_success_ind <= lo_succ_reg;
            inhibit_ind <= state_reg == ST_INHIBIT;
            locked_ind <= state_reg == ST_LOCKED;
        end
    end

endmodule // arst_status

/* test/arst_objctl_model.sv */
// Behavioural model of the breaker's object control function.
// Assumes it watches the recloser's indications and answers on its status.
`timescale 1ns/1ps

module arst_objctl_model (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Recloser indications and pace
    input wire arcing_time_ind,
    input wire dead_time_ind,
    input wire slow,
    // Breaker status
    output logic breaker_open,
    output logic breaker_closed
);
    logic arc_d, dead_d, pend_open, pend_close;
    logic [3:0] cnt;

    // Only this model moves the breaker; the recloser just indicates.
    always @(posedge clk) begin
        arc_d <= arcing_time_ind;
        dead_d <= dead_time_ind;
        if (rst) begin
            breaker_open <= 1'b0;
            breaker_closed <= 1'b1;
            pend_open <= 1'b0;
            pend_close <= 1'b0;
            cnt <= 4'h0;
        end else if (arc_d && !arcing_time_ind) begin
            pend_open <= 1'b1;
            cnt <= slow ? 4'h9 : 4'h1;
        end else if (dead_d && !dead_time_ind) begin
            pend_close <= 1'b1;
            cnt <= slow ? 4'h9 : 4'h1;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pend_open) begin
            breaker_open <= 1'b1;
            breaker_closed <= 1'b0;
            pend_open <= 1'b0;
        end else if (pend_close) begin
            breaker_open <= 1'b0;
            breaker_closed <= 1'b1;
            pend_close <= 1'b0;
        end
    end
endmodule // arst_objctl_model

/* test/arst_status_props.sv */
// Concurrent checks on the recloser status stage, bound to its top.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/1ps

module arst_status_chk (
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire ce,
    // Bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // Controls
    input wire critical_request,
    input wire manual_reset,
    // Indications
    input wire [4:0] shot_running_ind,
    input wire [4:0] request_active_ind,
    input wire recloser_enabled_ind,
    input wire recloser_disabled_ind,
    input wire reclose_in_progress_ind,
    input wire dead_time_ind,
    input wire locked_ind,
    input wire final_trip_ind,
    input wire lockout_success_ind,
    input wire sequence_done_ind,
    input wire reclaim_time_ind,
    input wire inhibit_ind,
    input wire recloser_ready_ind,
    input wire recloser_running_ind
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_answer: assert property
        (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    chk_one_shot: assert property
        ($onehot0(shot_running_ind) && $onehot0(request_active_ind))
        else $error("more than one shot or request shown");
    chk_dead_progress: assert property
        (dead_time_ind |-> reclose_in_progress_ind &&
         recloser_running_ind && shot_running_ind != 5'h00)
        else $error("dead time shown without in progress");
    chk_on_off_excl: assert property
        (!(recloser_enabled_ind && recloser_disabled_ind))
        else $error("enabled and disabled shown together");
    chk_critical_lock: assert property
        ($rose(critical_request) |-> ##[1:3] locked_ind)
        else $error("critical request did not lock");
    chk_locked_stays: assert property
        (locked_ind && !manual_reset && !$past(manual_reset) |=> locked_ind)
        else $error("locked left without manual reset");
    chk_final_locked: assert property
        (final_trip_ind |-> locked_ind)
        else $error("final trip shown outside locked");
    chk_lockout_locked: assert property
        ($rose(lockout_success_ind) |-> locked_ind && !recloser_ready_ind)
        else $error("lockout after success without lock");
    chk_done_reclaim: assert property
        (sequence_done_ind |-> reclaim_time_ind)
        else $error("sequence done outside reclaim");
    chk_inhibit_idle: assert property
        (inhibit_ind |-> !recloser_ready_ind && !recloser_running_ind)
        else $error("inhibit shown with ready or running");

    cov_final: cover property ($rose(final_trip_ind));
    cov_lockout: cover property ($rose(lockout_success_ind));
    cov_dead: cover property ($rose(dead_time_ind));
endmodule // arst_status_chk

bind arst_status arst_status_chk u_chk (.clk(clk), .rst(rst), .ce(ce),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .critical_request(critical_request), .manual_reset(manual_reset),
    .shot_running_ind(shot_running_ind),
    .request_active_ind(request_active_ind),
    .recloser_enabled_ind(recloser_enabled_ind),
    .recloser_disabled_ind(recloser_disabled_ind),
    .reclose_in_progress_ind(reclose_in_progress_ind),
    .dead_time_ind(dead_time_ind), .locked_ind(locked_ind),
    .final_trip_ind(final_trip_ind),
    .lockout_success_ind(lockout_success_ind),
    .sequence_done_ind(sequence_done_ind),
    .reclaim_time_ind(reclaim_time_ind), .inhibit_ind(inhibit_ind),
    .recloser_ready_ind(recloser_ready_ind),
    .recloser_running_ind(recloser_running_ind));

/* test/tb_top.sv */
// Self-checking bench for the recloser status stage.
// Assumes the object control model answers the breaker status.
`timescale 1ns/1ps

module tb_top;
    localparam int RDY = 0, DEAD = 1, RCL = 2, LCK = 3, ARC = 4;
    logic clk, rst, cyc, stb, we, ext, mrst, lock, crit, slow;
    logic [7:0] adr;
    logic [31:0] dat, r;
    logic [4:0] req, m;
    logic [31:0] exp_q[$];
    int n_fail = 0, cmp_count = 0;
    wire [31:0] rdat;
    wire ack, b_open, b_closed, en, dis, prog, run, done, ftrip, dead;
    wire arc, rcl, rdy, lsucc, inh, lck;
    wire [4:0] req_ind, shot_ind;

    arst_status #(.TICK_CYCLES(10)) uut (.clk(clk), .rst(rst), .ce(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .external_enable_input(ext), .manual_reset(mrst), .locking(lock),
        .critical_request(crit), .reclose_request_1(req[0]),
        .reclose_request_2(req[1]), .reclose_request_3(req[2]),
        .reclose_request_4(req[3]), .reclose_request_5(req[4]),
        .breaker_open(b_open), .breaker_closed(b_closed),
        .recloser_enabled_ind(en), .recloser_disabled_ind(dis),
        .reclose_in_progress_ind(prog), .recloser_running_ind(run),
        .request_active_ind(req_ind), .shot_running_ind(shot_ind),
        .sequence_done_ind(done), .final_trip_ind(ftrip),
        .dead_time_ind(dead), .arcing_time_ind(arc),
        .reclaim_time_ind(rcl), .recloser_ready_ind(rdy),
        .lockout_success_ind(lsucc), .inhibit_ind(inh), .locked_ind(lck));

    arst_objctl_model u_obj (.clk(clk), .rst(rst), .arcing_time_ind(arc),
        .dead_time_ind(dead), .slow(slow), .breaker_open(b_open),
        .breaker_closed(b_closed));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic ind(input int k);
        case (k)
            RDY: ind = rdy;
            DEAD: ind = dead;
            RCL: ind = rcl;
            LCK: ind = lck;
            default: ind = arc;
        endcase
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_ind(input int k, input logic v);
        int n;
        n = 0;
        while (ind(k) !== v && n < 3000) begin
            @(posedge clk);
            n++;
        end
        cmp(ind(k), v);
    endtask

    // For reads d is the expected word, queued for the monitor.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic unlock();
        mrst <= 1'b1;
        wait_ind(RDY, 1'b1);
        mrst <= 1'b0;
    endtask

    task summarize();
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
            if (exp_q.size() == 0) cmp(rdat, 32'hffffffff);
            else cmp(rdat, exp_q.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #300000;
        n_fail++;
        summarize();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {rst, cyc, stb, we, ext, mrst, lock, crit, slow} = 9'h101;
        {adr, dat, req} = '0;
        r = $urandom(4642);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        cmp({req_ind, shot_ind, en, dis, prog, run, lck, rdy}, 32'h0);
        repeat (3) @(posedge clk);
        cmp(inh, 1'b1);
        bus(0, 8'h00, 32'h12);
        bus(0, 8'h04, 32'h64);
        bus(0, 8'h08, 32'h1f4);
        bus(0, 8'h0c, 32'h2710);
        bus(0, 8'h10, 32'h2710);
        bus(1, 8'h20, 32'h5);
        bus(0, 8'h20, 32'h0);
        bus(1, 8'h04, 32'h3);
        bus(1, 8'h08, 32'h4);
        bus(1, 8'h0c, 32'h5);
        bus(1, 8'h10, 32'h5);
        bus(1, 8'h00, 32'h13);
        wait_ind(RDY, 1'b1);
        cmp(en, 1'b1);
        r = $urandom % 31 + 1;
        m = r[4:0];
        req <= m;
        wait_ind(ARC, 1'b1);
        cmp(req_ind, m & (~m + 5'h01));
        cmp(shot_ind, 5'h01);
        cmp(run, 1'b1);
        wait_ind(DEAD, 1'b1);
        cmp(prog, 1'b1);
        req <= 5'h00;
        wait_ind(RCL, 1'b1);
        cmp(done, 1'b1);
        req <= 5'h02;
        wait_ind(LCK, 1'b1);
        cmp(ftrip, 1'b1);
        req <= 5'h00;
        repeat (20) @(posedge clk);
        cmp(lck, 1'b1);
        unlock();
        cmp(ftrip, 1'b0);
        slow <= 1'b0;
        req <= 5'h01;
        wait_ind(DEAD, 1'b1);
        req <= 5'h00;
        wait_ind(RCL, 1'b1);
        wait_ind(RCL, 1'b0);
        req <= 5'h08;
        wait_ind(LCK, 1'b1);
        cmp(lsucc, 1'b1);
        req <= 5'h00;
        unlock();
        for (int k = 0; k < 2; k++) begin
            crit <= (k == 0);
            lock <= (k == 1);
            repeat (3) @(posedge clk);
            cmp(lck, 1'b1);
            {crit, lock} <= 2'b00;
            unlock();
        end
        bus(1, 8'h00, 32'h23);
        req <= 5'h0c;
        wait_ind(DEAD, 1'b1);
        wait_ind(ARC, 1'b1);
        cmp({req_ind, shot_ind}, 10'h082);
        wait_ind(DEAD, 1'b1);
        req <= 5'h00;
        wait_ind(RCL, 1'b1);
        cmp(done, 1'b1);
        wait_ind(RCL, 1'b0);
        cmp(done, 1'b0);
        bus(1, 8'h00, 32'h11);
        repeat (3) @(posedge clk);
        cmp(dis, 1'b1);
        cmp(en, 1'b0);
        ext <= 1'b1;
        repeat (3) @(posedge clk);
        cmp({en, dis}, 2'b10);
        bus(0, 8'h14, 32'h21);
        summarize();
    end
endmodule // tb_top
